// >>> src/cefm_event_flag_mask.sv
`timescale 1ns/1ps
`default_nettype none
module cefm_event_flag_mask #(
  parameter int PULSE_CYCLES = cefm_pkg::INT_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register access from the serial bus engine
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic REG_RESET_CMD,
  // Status codes from the charger core
  input wire logic [1:0] CHARGE_STATE_CODE,
  input wire logic [2:0] INPUT_SUPPLY_CODE,
  input wire logic [2:0] THERMISTOR_ZONE_CODE,
  // Fault detector levels
  input wire logic INPUT_OVERVOLT_SLEEP,
  input wire logic BATTERY_PROTECT,
  input wire logic SYSTEM_RAIL_FAULT,
  input wire logic DIE_OVERHEAT,
  // Charger regulation and timer levels
  input wire logic ADC_DONE,
  input wire logic ADC_ONE_SHOT,
  input wire logic DIE_THERMAL_REGULATION,
  input wire logic MINIMUM_SYSTEM_VOLTAGE,
  input wire logic INPUT_CURRENT_REGULATION,
  input wire logic INPUT_VOLTAGE_REGULATION,
  input wire logic CHARGE_TIMER_EXPIRED,
  input wire logic BUS_WATCHDOG_EXPIRED,
  // Fault mask byte held by the neighbouring register
  input wire logic [7:0] FAULT_MASK,
  // Interrupt
  output logic INT_N
);

  localparam int NSYNC = 22;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] prev;
  logic primed;
  logic [1:0] warmup;

  assign raw_in = {
    CHARGE_STATE_CODE, INPUT_SUPPLY_CODE, THERMISTOR_ZONE_CODE,
    INPUT_OVERVOLT_SLEEP, BATTERY_PROTECT, SYSTEM_RAIL_FAULT,
    DIE_OVERHEAT, ADC_DONE, ADC_ONE_SHOT, DIE_THERMAL_REGULATION,
    MINIMUM_SYSTEM_VOLTAGE, INPUT_CURRENT_REGULATION,
    INPUT_VOLTAGE_REGULATION, CHARGE_TIMER_EXPIRED,
    BUS_WATCHDOG_EXPIRED, 2'b00
  };

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // Compare only once prev holds a full synced sample, not reset zeros
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prev <= '0;
      warmup <= '0;
      primed <= 1'b0;
    end else begin
      prev <= sync_b;
      warmup <= {warmup[0], 1'b1};
      primed <= warmup[1];
    end
  end

  // ****************************************
  // Field views of synchronised inputs
  // ****************************************
  logic [1:0] charge_state_code;
  logic [2:0] input_supply_code;
  logic [2:0] thermistor_zone_code;
  logic [1:0] charge_state_old;
  logic [2:0] input_supply_old;
  logic [2:0] thermistor_zone_old;

  assign charge_state_code = sync_b[21:20]; // RULE17
  assign input_supply_code = sync_b[19:17];
  assign thermistor_zone_code = sync_b[16:14]; // RULE18
  assign charge_state_old = prev[21:20];
  assign input_supply_old = prev[19:17];
  assign thermistor_zone_old = prev[16:14];

  function automatic logic rose(input int idx, input logic [NSYNC-1:0] now,
                                input logic [NSYNC-1:0] was);
    rose = now[idx] & ~was[idx];
  endfunction

  // ****************************************
  // Event detection
  // ****************************************
  logic ev_charge_state;
  logic ev_input_supply;
  logic ev_overvolt_sleep;
  logic ev_battery_protect;
  logic ev_system_rail;
  logic ev_die_overheat;
  logic ev_thermistor_zone;
  logic ev_adc_done;
  logic ev_thermal_reg;
  logic ev_min_system;
  logic ev_current_limit;
  logic ev_voltage_limit;
  logic ev_charge_timer;
  logic ev_watchdog;

  assign ev_charge_state = primed &&
    (charge_state_code != charge_state_old); // RULE1
  assign ev_input_supply = primed &&
    (input_supply_code != input_supply_old); // RULE2
  assign ev_thermistor_zone = primed &&
    (thermistor_zone_code != thermistor_zone_old); // RULE7
  assign ev_overvolt_sleep = primed && rose(13, sync_b, prev); // RULE3
  assign ev_battery_protect = primed && rose(12, sync_b, prev); // RULE4
  assign ev_system_rail = primed && rose(11, sync_b, prev); // RULE5
  assign ev_die_overheat = primed && rose(10, sync_b, prev); // RULE6
  // ADC completion is only reported in one-shot mode
  assign ev_adc_done = primed && sync_b[8] && rose(9, sync_b, prev);
  assign ev_thermal_reg = primed && rose(7, sync_b, prev);
  // Both entry and exit of minimum system regulation count
  assign ev_min_system = primed && (sync_b[6] != prev[6]);
  assign ev_current_limit = primed && rose(5, sync_b, prev);
  assign ev_voltage_limit = primed && rose(4, sync_b, prev);
  assign ev_charge_timer = primed && rose(3, sync_b, prev);
  assign ev_watchdog = primed && rose(2, sync_b, prev);

  // ****************************************
  // Register access decode
  // ****************************************
  logic rd_flags_b;
  logic rd_fault;
  logic wr_mask_a;
  logic wr_mask_b;

  always_comb begin
    rd_flags_b = 1'b0;
    rd_fault = 1'b0;
    wr_mask_a = 1'b0;
    wr_mask_b = 1'b0;
    if (REG_ADDR == cefm_pkg::ADDR_CHARGER_EVENT_FLAGS_B) begin
      rd_flags_b = REG_RD;
    end else if (REG_ADDR == cefm_pkg::ADDR_FAULT_EVENT_FLAGS) begin
      rd_fault = REG_RD;
    end else if (REG_ADDR == cefm_pkg::ADDR_CHARGER_EVENT_MASK_A) begin
      wr_mask_a = REG_WR;
    end else if (REG_ADDR == cefm_pkg::ADDR_CHARGER_EVENT_MASK_B) begin
      wr_mask_b = REG_WR;
    end
  end

  // ****************************************
  // Flag registers
  // ****************************************
  logic [7:0] charger_event_flags_b;
  logic [7:0] fault_event_flags;
  logic [7:0] set_flags_b;
  logic [7:0] set_fault;
  logic [7:0] next_flags_b;
  logic [7:0] next_fault;

  always_comb begin
    set_flags_b = '0;
    set_flags_b[cefm_pkg::BIT_CHARGE_STATE_CHANGE_FLAG] =
      ev_charge_state; // RULE1
    set_flags_b[cefm_pkg::BIT_INPUT_SUPPLY_CHANGE_FLAG] =
      ev_input_supply; // RULE2
    set_fault = '0;
    set_fault[cefm_pkg::BIT_INPUT_OVERVOLT_SLEEP_FLAG] =
      ev_overvolt_sleep; // RULE3
    set_fault[cefm_pkg::BIT_BATTERY_PROTECT_FLAG] =
      ev_battery_protect; // RULE4
    set_fault[cefm_pkg::BIT_SYSTEM_RAIL_FAULT_FLAG] = ev_system_rail; // RULE5
    set_fault[cefm_pkg::BIT_DIE_OVERHEAT_FLAG] = ev_die_overheat; // RULE6
    set_fault[cefm_pkg::BIT_THERMISTOR_ZONE_CHANGE_FLAG] =
      ev_thermistor_zone; // RULE7
  end

  // A read clears the flags, but an event in the same cycle survives
  always_comb begin
    next_flags_b = rd_flags_b ? set_flags_b
      : (charger_event_flags_b | set_flags_b); // RULE21
    next_fault = rd_fault ? set_fault
                          : (fault_event_flags | set_fault); // RULE21
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      charger_event_flags_b <= cefm_pkg::RESET_BYTE;
      fault_event_flags <= cefm_pkg::RESET_BYTE;
    end else begin
      charger_event_flags_b <= next_flags_b &
        cefm_pkg::USED_CHARGER_EVENT_FLAGS_B;
      fault_event_flags <= next_fault & cefm_pkg::USED_FAULT_EVENT_FLAGS;
    end
  end

  // ****************************************
  // Mask registers
  // ****************************************
  logic [7:0] charger_event_mask_a;
  logic [7:0] charger_event_mask_b;

  always_ff @(posedge REF_CLK) begin
    if (RST || REG_RESET_CMD) begin
      charger_event_mask_a <= cefm_pkg::RESET_BYTE; // RULE20
      charger_event_mask_b <= cefm_pkg::RESET_BYTE; // RULE20
    end else begin
      if (wr_mask_a) begin
        charger_event_mask_a <= REG_WDATA &
          cefm_pkg::USED_CHARGER_EVENT_MASK_A; // RULE20
      end
      if (wr_mask_b) begin
        charger_event_mask_b <= REG_WDATA &
          cefm_pkg::USED_CHARGER_EVENT_MASK_B; // RULE20
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (REG_ADDR == cefm_pkg::ADDR_CHARGER_EVENT_FLAGS_B) begin
      next_rdata = charger_event_flags_b;
    end else if (REG_ADDR == cefm_pkg::ADDR_FAULT_EVENT_FLAGS) begin
      next_rdata = fault_event_flags;
    end else if (REG_ADDR == cefm_pkg::ADDR_CHARGER_EVENT_MASK_A) begin
      next_rdata = charger_event_mask_a;
    end else if (REG_ADDR == cefm_pkg::ADDR_CHARGER_EVENT_MASK_B) begin
      next_rdata = charger_event_mask_b;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= cefm_pkg::RESET_BYTE;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata; // RULE20
    end
  end

  // ****************************************
  // Interrupt gating
  // ****************************************
  logic [7:0] ma;
  logic [7:0] mb;
  logic irq_event;

  assign ma = charger_event_mask_a;
  assign mb = charger_event_mask_b;

  always_comb begin
    irq_event =
      (ev_adc_done &&
       !ma[cefm_pkg::BIT_ADC_DONE_IRQ_BLOCK]) || // RULE8
      (ev_thermal_reg &&
       !ma[cefm_pkg::BIT_THERMAL_REGULATION_IRQ_BLOCK]) || // RULE9
      (ev_min_system &&
       !ma[cefm_pkg::BIT_MIN_SYSTEM_VOLTAGE_IRQ_BLOCK]) || // RULE10
      (ev_current_limit &&
       !ma[cefm_pkg::BIT_INPUT_CURRENT_LIMIT_IRQ_BLOCK]) || // RULE11
      (ev_voltage_limit &&
       !ma[cefm_pkg::BIT_INPUT_VOLTAGE_LIMIT_IRQ_BLOCK]) || // RULE12
      (ev_charge_timer &&
       !ma[cefm_pkg::BIT_CHARGE_TIMER_EXPIRY_IRQ_BLOCK]) || // RULE13
      (ev_watchdog &&
       !ma[cefm_pkg::BIT_BUS_WATCHDOG_IRQ_BLOCK]) || // RULE14
      (ev_charge_state &&
       !mb[cefm_pkg::BIT_CHARGE_STATE_IRQ_BLOCK]) || // RULE15
      (ev_input_supply &&
       !mb[cefm_pkg::BIT_INPUT_SUPPLY_IRQ_BLOCK]) || // RULE16
      (|(set_fault & ~FAULT_MASK));
  end

  // ****************************************
  // Interrupt pulse
  // ****************************************
  localparam logic [cefm_pkg::INT_COUNT_WIDTH-1:0] PULSE_LAST =
    cefm_pkg::INT_COUNT_WIDTH'(PULSE_CYCLES - 1);
  localparam logic [cefm_pkg::INT_COUNT_WIDTH-1:0] COUNT_ZERO = '0;

  logic [cefm_pkg::INT_COUNT_WIDTH-1:0] pulse_count;
  logic pulse_on;

  // Events during a pulse merge into it; host reads flags afterwards
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pulse_on <= 1'b0;
      pulse_count <= COUNT_ZERO;
    end else if (!pulse_on && irq_event) begin
      pulse_on <= 1'b1; // RULE19
      pulse_count <= PULSE_LAST;
    end else if (pulse_on) begin
      if (pulse_count == COUNT_ZERO) begin
        pulse_on <= 1'b0;
      end else begin
        pulse_count <= pulse_count - 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= ~pulse_on; // RULE19
    end
  end

endmodule
`default_nettype wire

// >>> src/cefm_pkg.sv
// Behaviour
// [RULE1] Charge code change sets charger flag bit 3
// [RULE2] Supply code change sets charger flag bit 0
// [RULE3] Input overvoltage or sleep sets fault bit 7
// [RULE4] Battery overcurrent or overvoltage sets fault bit 6
// [RULE5] System overvoltage or short sets fault bit 5
// [RULE6] Thermal shutdown rising edge sets fault bit 3
// [RULE7] Thermistor zone change sets fault bit 0
// [RULE8] Mask A bit 6 blocks ADC-done pulse
// [RULE9] Mask A bit 5 blocks thermal regulation pulse
// [RULE10] Mask A bit 4 blocks min-system enter/exit pulse
// [RULE11] Mask A bit 3 blocks input current limit pulse
// [RULE12] Mask A bit 2 blocks input voltage limit pulse
// [RULE13] Mask A bit 1 blocks charge timer expiry pulse
// [RULE14] Mask A bit 0 blocks bus watchdog pulse
// [RULE15] Mask B bit 3 blocks charge state pulse
// [RULE16] Mask B bit 0 blocks input supply pulse
// [RULE17] Charge code: idle, CC, CV, top-off
// [RULE18] Thermistor zone is a three-bit code
// [RULE19] Unmasked new event gives one low pulse
// [RULE20] Masks clear on reset; reserved bits read 0
// [RULE21] Flags hold until read, then clear
package cefm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CHARGER_EVENT_FLAGS_B = 8'h21;
  localparam logic [7:0] ADDR_FAULT_EVENT_FLAGS = 8'h22;
  localparam logic [7:0] ADDR_CHARGER_EVENT_MASK_A = 8'h23;
  localparam logic [7:0] ADDR_CHARGER_EVENT_MASK_B = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CHARGE_STATE_CHANGE_FLAG = 3;
  localparam int BIT_INPUT_SUPPLY_CHANGE_FLAG = 0;
  localparam int BIT_INPUT_OVERVOLT_SLEEP_FLAG = 7;
  localparam int BIT_BATTERY_PROTECT_FLAG = 6;
  localparam int BIT_SYSTEM_RAIL_FAULT_FLAG = 5;
  localparam int BIT_DIE_OVERHEAT_FLAG = 3;
  localparam int BIT_THERMISTOR_ZONE_CHANGE_FLAG = 0;
  localparam int BIT_ADC_DONE_IRQ_BLOCK = 6;
  localparam int BIT_THERMAL_REGULATION_IRQ_BLOCK = 5;
  localparam int BIT_MIN_SYSTEM_VOLTAGE_IRQ_BLOCK = 4;
  localparam int BIT_INPUT_CURRENT_LIMIT_IRQ_BLOCK = 3;
  localparam int BIT_INPUT_VOLTAGE_LIMIT_IRQ_BLOCK = 2;
  localparam int BIT_CHARGE_TIMER_EXPIRY_IRQ_BLOCK = 1;
  localparam int BIT_BUS_WATCHDOG_IRQ_BLOCK = 0;
  localparam int BIT_CHARGE_STATE_IRQ_BLOCK = 3;
  localparam int BIT_INPUT_SUPPLY_IRQ_BLOCK = 0;

  // Implemented bits of each register (flags read-only, masks writable); the rest read as zero
  localparam logic [7:0] USED_CHARGER_EVENT_FLAGS_B = 8'h09;
  localparam logic [7:0] USED_FAULT_EVENT_FLAGS = 8'hE9;
  localparam logic [7:0] USED_CHARGER_EVENT_MASK_A = 8'h7F;
  localparam logic [7:0] USED_CHARGER_EVENT_MASK_B = 8'h09;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ****************************************
  // Status codes
  // ****************************************
  typedef enum logic [1:0] {
    CEFM_CHG_IDLE = 2'b00,
    CEFM_CHG_CONST_CURRENT = 2'b01,
    CEFM_CHG_CONST_VOLTAGE = 2'b10,
    CEFM_CHG_TOP_OFF = 2'b11
  } cefm_charge_state_t;

  typedef enum logic [2:0] {
    CEFM_ZONE_NORMAL = 3'b000,
    CEFM_ZONE_COLD = 3'b001,
    CEFM_ZONE_HOT = 3'b010,
    CEFM_ZONE_COOL = 3'b011,
    CEFM_ZONE_WARM = 3'b100,
    CEFM_ZONE_PRECOOL = 3'b101,
    CEFM_ZONE_PREWARM = 3'b110,
    CEFM_ZONE_BIAS_FAULT = 3'b111
  } cefm_thermistor_zone_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_PERIOD_PS = 5000;
  localparam int INT_PULSE_WIDTH_NS = 256;
  localparam int INT_PULSE_CYCLES =
    (INT_PULSE_WIDTH_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int INT_COUNT_WIDTH = 8;

endpackage

// >>> test/cefm_event_flag_mask_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cefm_asserts #(
  parameter int PULSE_CYCLES = 4
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RESET_CMD,
  // Events
  input wire logic [1:0] CHARGE_STATE_CODE,
  input wire logic DIE_OVERHEAT,
  input wire logic MINIMUM_SYSTEM_VOLTAGE,
  input wire logic [7:0] FAULT_MASK,
  // Interrupt
  input wire logic INT_N
);
  logic [7:0] ma, mb, used, msel;
  logic [2:0] sr;
  int lc;
  // Shadow copies of the two mask registers
  always_ff @(posedge REF_CLK) begin
    if (RST || REG_RESET_CMD) begin
      ma <= 8'h00;
      mb <= 8'h00;
    end else if (REG_WR && REG_ADDR == 8'h23) begin
      ma <= REG_WDATA & 8'h7F;
    end else if (REG_WR && REG_ADDR == 8'h24) begin
      mb <= REG_WDATA & 8'h09;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sr <= 3'd0;
    end else if (sr != 3'd7) begin
      sr <= sr + 3'd1;
    end
  end
  always_ff @(posedge REF_CLK) begin
    lc <= (RST || INT_N) ? 0 : lc + 1;
  end
  always_comb begin
    msel = REG_ADDR[0] ? ma : mb;
    case (REG_ADDR)
      8'h21: used = 8'h09;
      8'h22: used = 8'hE9;
      8'h23: used = 8'h7F;
      8'h24: used = 8'h09;
      default: used = 8'h00;
    endcase
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_reset;
    disable iff (1'b0) RST |=> INT_N && REG_RDATA == 8'h00;
  endproperty
  property p_width;
    $rose(INT_N) && !$past(RST) |-> lc == PULSE_CYCLES;
  endproperty
  property p_resv;
    REG_RD |=> (REG_RDATA & ~$past(used)) == 8'h00;
  endproperty
  property p_hold;
    !REG_RD |=> $stable(REG_RDATA);
  endproperty
  property p_maskrd;
    REG_RD && !REG_WR && !REG_RESET_CMD && REG_ADDR inside {8'h23, 8'h24}
      |=> REG_RDATA == $past(msel);
  endproperty
  property p_charge;
    $changed(CHARGE_STATE_CODE) && !mb[3] && INT_N && sr == 3'd7
      |-> ##[1:8] !INT_N;
  endproperty
  property p_heat;
    $rose(DIE_OVERHEAT) && !FAULT_MASK[3] && INT_N && sr == 3'd7
      |-> ##[1:8] !INT_N;
  endproperty
  property p_minsys;
    $fell(MINIMUM_SYSTEM_VOLTAGE) && !ma[4] && INT_N && sr == 3'd7
      |-> ##[1:8] !INT_N;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset");
  a_width: assert property (p_width) else $error("bad width");
  a_resv: assert property (p_resv) else $error("bad reserved");
  a_hold: assert property (p_hold) else $error("read moved");
  a_maskrd: assert property (p_maskrd) else $error("bad mask");
  a_charge: assert property (p_charge) else $error("no irq");
  a_heat: assert property (p_heat) else $error("no irq");
  a_minsys: assert property (p_minsys) else $error("no irq");
  c_pulse: cover property ($fell(INT_N));
  c_fault_rd: cover property (REG_RD && REG_ADDR == 8'h22);
  c_cmd: cover property (REG_RESET_CMD);
endmodule
bind cefm_event_flag_mask cefm_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .REG_RESET_CMD(REG_RESET_CMD), .CHARGE_STATE_CODE(CHARGE_STATE_CODE),
  .DIE_OVERHEAT(DIE_OVERHEAT), .MINIMUM_SYSTEM_VOLTAGE(MINIMUM_SYSTEM_VOLTAGE),
  .FAULT_MASK(FAULT_MASK), .INT_N(INT_N)
);
`default_nettype wire

// >>> test/cefm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cefm_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PC = 4;
  localparam int fbit[7] = '{3, 0, 7, 6, 5, 3, 0};
  logic clk = 1'b0, rst = 1'b1, cmd = 1'b0, one_shot = 1'b1;
  logic [1:0] cs = 2'b00;
  logic [2:0] sup = 3'b000, zone = 3'b000;
  logic [13:0] lvl = 14'h0000;
  logic [7:0] fmask = 8'h00, rdata, addr, wdata, got;
  logic wr, rd, int_n;
  int err_total = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  cefm_host_model u_host (.ref_clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata));
  cefm_event_flag_mask #(.PULSE_CYCLES(PC)) uut (
    .REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RESET_CMD(cmd),
    .CHARGE_STATE_CODE(cs), .INPUT_SUPPLY_CODE(sup),
    .THERMISTOR_ZONE_CODE(zone), .INPUT_OVERVOLT_SLEEP(lvl[2]),
    .BATTERY_PROTECT(lvl[3]), .SYSTEM_RAIL_FAULT(lvl[4]),
    .DIE_OVERHEAT(lvl[5]), .ADC_DONE(lvl[7]), .ADC_ONE_SHOT(one_shot),
    .DIE_THERMAL_REGULATION(lvl[8]), .MINIMUM_SYSTEM_VOLTAGE(lvl[9]),
    .INPUT_CURRENT_REGULATION(lvl[10]), .INPUT_VOLTAGE_REGULATION(lvl[11]),
    .CHARGE_TIMER_EXPIRED(lvl[12]), .BUS_WATCHDOG_EXPIRED(lvl[13]),
    .FAULT_MASK(fmask), .INT_N(int_n));
  // ****
  // Helpers
  // ****
  task automatic chk(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic watch(output logic [7:0] n);
    n = 8'h00;
    repeat (12) begin
      @(negedge clk);
      if (int_n === 1'b0) n++;
    end
  endtask
  // Low cycles expected on the interrupt for one rising event
  function automatic logic [7:0] exp_irq(input int idx, input bit masked);
    exp_irq = (masked || (idx == 7 && !one_shot)) ? 8'h00 : 8'(PC);
  endfunction
  // One event with its own mask bit set or every other mask bit set
  task automatic run(input int idx, input bit masked);
    logic [7:0] m, n, b, ex, fa;
    b = 8'h01 << (idx < 7 ? fbit[idx] : 13 - idx);
    m = masked ? b : ~b;
    fmask = (idx > 1 && idx < 7) ? m : 8'h00;
    u_host.wr(8'h23, idx > 6 ? m : 8'h00);
    u_host.wr(8'h24, idx < 2 ? m : 8'h00);
    case (idx)
      0: cs ^= 2'(($urandom % 3) + 1);
      1: sup ^= 3'(($urandom % 7) + 1);
      6: zone ^= 3'(($urandom % 7) + 1);
      default: lvl[idx] = ~lvl[idx];
    endcase
    watch(n);
    ex = exp_irq(idx, masked);
    if (idx < 7) chk("irq", n, ex);
    else chk("irq", n, ex);
    if (idx < 7) begin
      fa = idx < 2 ? 8'h21 : 8'h22;
      u_host.rd(fa, got);
      ex = 8'h01 << fbit[idx];
      chk("flag", got, ex);
      u_host.rd(fa, got);
      chk("cleared", got, 8'h00);
    end
    if (idx > 1 && idx != 6) begin
      lvl[idx] = ~lvl[idx];
      watch(n);
      ex = (idx == 9 && !masked) ? 8'(PC) : 8'h00;
      chk("fall irq", n, ex);
      if (idx < 6) begin
        u_host.rd(8'h22, got);
        chk("fall flag", got, 8'h00);
      end
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    logic [7:0] v;
    void'($urandom(32'hb87e));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int a = 8'h20; a < 8'h26; a++) begin
      u_host.rd(8'(a), got);
      chk("reset value", got, 8'h00);
    end
    repeat (6) begin
      v = 8'($urandom);
      u_host.wr(8'h23, v);
      u_host.wr(8'h24, v);
      u_host.wr(8'h21, v);
      u_host.rd(8'h23, got);
      chk("mask a", got, v & 8'h7F);
      u_host.rd(8'h24, got);
      chk("mask b", got, v & 8'h09);
      u_host.rd(8'h21, got);
      chk("flags ro", got, 8'h00);
    end
    @(negedge clk);
    cmd = 1'b1;
    @(negedge clk);
    cmd = 1'b0;
    u_host.rd(8'h23, got);
    chk("cmd mask a", got, 8'h00);
    u_host.rd(8'h24, got);
    chk("cmd mask b", got, 8'h00);
    for (int i = 0; i < 28; i++) run(i / 2, i[0]);
    one_shot = 1'b0;
    run(7, 1'b0);
    one_shot = 1'b1;
    repeat (20) run($urandom % 14, 1'($urandom % 2));
    u_host.wr(8'h24, 8'h09);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    u_host.rd(8'h24, got);
    chk("mask after reset", got, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
